// [shared/hpp_pkg.sv]
// Purpose: Shared constants and types of the handshake parallel port.
// Assumes: One state equals one pclk period (100 MHz, 10 ns).
// Notes: Register byte offsets serve both ends' APB slaves.
package hpp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned STATE_NS = 1000 / CLK_MHZ;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TX = 8'h08;
  localparam logic [7:0] REG_RX = 8'h0C;
  localparam int unsigned CTRL_DUAL_PORT = 0;
  localparam int unsigned CTRL_HANDSHAKE = 1;
  localparam int unsigned CTRL_REQ_OUT_EN = 2;
  localparam int unsigned CTRL_USE_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_FF04;
  localparam int unsigned ST_EMPTY = 0;
  localparam int unsigned ST_FULL = 1;
  localparam int unsigned ST_BUSY = 2;
  localparam int unsigned HCTRL_RX_EN = 0;
  localparam int unsigned HCTRL_CS_EN = 1;
  localparam int unsigned HCTRL_RS_LSB = 2;
  localparam int unsigned HST_TX_BUSY = 0;
  localparam int unsigned HST_RX_FULL = 1;
  localparam int unsigned SYN_OE = 8;
  localparam int unsigned SYN_WE = 9;
  localparam int unsigned SYN_CS = 10;
  localparam int unsigned SYN_RS = 11;
  localparam int unsigned HSYN_REQ = 8;
  // Timing in clock cycles (one state = one clock)
  localparam int unsigned REQ_PULSE_CYC = 8;
  localparam int unsigned LAG_BB_TENTHS = 35;
  localparam int unsigned LAG_BQ_STATES = 3;
  localparam int unsigned BUS_WAIT_STATES = 6;
  localparam int unsigned RAM_STATES = 2;
  localparam int unsigned LAG_CYC = LAG_BB_TENTHS / 10;
  localparam int unsigned XFER_BUSY_CYC = LAG_CYC + BUS_WAIT_STATES
                                          + RAM_STATES;
  localparam int unsigned GAP_BB_TENTHS = 95;
  localparam int unsigned GAP_BQ_STATES = 11;
  localparam int unsigned GAP_CYC = (GAP_BB_TENTHS + 9) / 10;
  localparam int unsigned STROBE_MIN_STATES = 2;
  localparam int unsigned WE_LOW_CYC = 4;
  typedef enum logic [1:0] {
    HPP_TX_IDLE = 2'b00,
    HPP_TX_WAIT = 2'b01,
    HPP_TX_DRIVE = 2'b10
  } hpp_tx_t;
  typedef enum logic [1:0] {
    HPP_H_IDLE = 2'b00,
    HPP_H_STROBE = 2'b01,
    HPP_H_HOLD = 2'b10,
    HPP_H_GAP = 2'b11
  } hpp_host_st_t;
endpackage

// [shared/hpp_if.sv]
// Purpose: Pin bundle between the port and its peer master.
// Assumes: Data and request lines are pulled high when undriven.
// Notes: Wire levels are resolved here from the drive enables.
`timescale 1ns/1ps
interface hpp_if;
  logic oe_n;
  logic we_n;
  logic cs_n;
  logic [2:0] rs;
  logic [7:0] dev_data_o;
  logic dev_data_oe;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [7:0] data;
  logic wait_request_o;
  logic wait_request_oe;
  logic wait_request_out;
  logic ready_n;
  assign data = dev_data_oe ? dev_data_o :
                (host_data_oe ? host_data_o : 8'hFF);
  assign wait_request_out = wait_request_oe ? wait_request_o : 1'b1;
  modport dev (input oe_n, we_n, cs_n, rs, data,
               output dev_data_o, dev_data_oe, wait_request_o,
               wait_request_oe, ready_n);
  modport host (output oe_n, we_n, cs_n, rs, host_data_o, host_data_oe,
                input data, wait_request_out, ready_n);
endinterface

// [hw/hpp_dev.sv]
// Purpose: Device end of the handshake parallel port, APB on CPU side.
// Assumes: Pins are asynchronous to pclk; APB master on pclk.
// Notes: Dual-port modes only model the wait-request timing.
`timescale 1ns/1ps
module hpp_dev
  import hpp_pkg::*;
#(
  parameter int unsigned BUSY_CYC = XFER_BUSY_CYC
) (
  input wire logic pclk,           // System clock
  input wire logic presetn,        // Async reset, active low
  input wire logic psel,           // APB select
  input wire logic penable,        // APB access phase
  input wire logic pwrite,         // APB direction
  input wire logic [7:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,      // APB read data
  output logic pready,             // APB ready
  output logic pslverr,            // APB error, unmapped address
  hpp_if.dev port                  // Pins to the peer
);

  typedef struct packed {
    logic [13:0] s1;
    logic [13:0] s2;
    logic [13:0] s3;
    logic [13:0] flt;
    logic [13:0] flt_d;
    logic dual_port_mode_enable;
    logic handshake_select_enable;
    logic wait_request_output_enable;
    logic [7:0] usable;
    logic empty;
    logic full;
    logic [7:0] out_data;
    logic [7:0] in_data;
    hpp_tx_t tx;
    logic [3:0] cnt;
    logic rdy_low;
    logic [3:0] busy;
    logic [31:0] rdata;
    logic err;
  } hpp_dev_state_t;

  hpp_dev_state_t st;
  hpp_dev_state_t next_st;

  logic hs;
  logic setup;
  logic access;
  logic mapped;
  logic oe_l;
  logic we_l;
  logic cs_l;
  logic [2:0] rs_v;
  logic we_fall;
  logic we_rise;
  logic oe_rise;
  logic req_low;

  function automatic logic is_mapped(input logic [7:0] a);
    if (a == REG_CTRL) begin
      return 1'b1;
    end else if (a == REG_STAT) begin
      return 1'b1;
    end else if (a == REG_TX) begin
      return 1'b1;
    end else if (a == REG_RX) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  assign hs = st.dual_port_mode_enable
              & st.handshake_select_enable;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = is_mapped(paddr);
  assign oe_l = ~st.flt[SYN_OE];
  assign we_l = ~st.flt[SYN_WE];
  assign cs_l = ~st.flt[SYN_CS];
  assign rs_v = st.flt[SYN_RS +: 3];
  assign we_fall = st.flt_d[SYN_WE] & ~st.flt[SYN_WE];
  assign we_rise = ~st.flt_d[SYN_WE] & st.flt[SYN_WE];
  assign oe_rise = ~st.flt_d[SYN_OE] & st.flt[SYN_OE];

  always_comb begin
    next_st = st;
    // Three-stage sampling; a change counts once stages two and three agree
    next_st.s1 = {port.rs, port.cs_n, port.we_n, port.oe_n, port.data};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.flt = (st.s3 & ~(st.s2 ^ st.s3))
                  | (st.flt & (st.s2 ^ st.s3));
    next_st.flt_d = st.flt;

    // APB read data is prepared in the setup cycle
    if (setup) begin
      next_st.err = ~mapped;
      if (paddr == REG_CTRL) begin
        next_st.rdata = {16'h0000, st.usable, 5'h00,
                         st.wait_request_output_enable,
                         st.handshake_select_enable,
                         st.dual_port_mode_enable};
      end else if (paddr == REG_STAT) begin
        next_st.rdata = {29'h0000_0000, st.tx != HPP_TX_IDLE, st.full,
                         st.empty};
      end else if (paddr == REG_TX) begin
        next_st.rdata = {24'h00_0000, st.out_data};
      end else if (paddr == REG_RX) begin
        next_st.rdata = {24'h00_0000, st.in_data};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    // Inbound read clears first so a same-cycle capture still wins
    if (access && !pwrite && paddr == REG_RX && st.full) begin
      next_st.full = 1'b0;
      next_st.rdy_low = 1'b0;
    end

    if (access && pwrite) begin
      if (paddr == REG_CTRL) begin
        next_st.dual_port_mode_enable = pwdata[CTRL_DUAL_PORT];
        next_st.handshake_select_enable = pwdata[CTRL_HANDSHAKE];
        next_st.wait_request_output_enable = pwdata[CTRL_REQ_OUT_EN];
        next_st.usable = pwdata[CTRL_USE_LSB +: 8];
      end else if (paddr == REG_TX) begin
        // A write while a byte is pending only overwrites nothing
        if (st.empty || !hs) begin
          next_st.out_data = pwdata[7:0];
        end
        if (hs && st.empty) begin
          next_st.empty = 1'b0;
          next_st.tx = HPP_TX_WAIT;
        end
      end
    end

    // Transmit sequence
    case (st.tx)
      HPP_TX_WAIT: begin
        if (oe_l) begin
          next_st.tx = HPP_TX_DRIVE;
          next_st.cnt = 4'h0;
        end
      end
      HPP_TX_DRIVE: begin
        if (st.cnt < 4'(REQ_PULSE_CYC)) begin
          next_st.cnt = st.cnt + 4'h1;
        end
        if (!oe_l) begin
          next_st.tx = HPP_TX_IDLE;
          next_st.empty = 1'b1;
        end
      end
      default: begin
        next_st.cnt = 4'h0;
      end
    endcase
    if (!hs && st.tx != HPP_TX_IDLE) begin
      // Leaving handshake mode abandons the byte and frees the buffer
      next_st.tx = HPP_TX_IDLE;
      next_st.empty = 1'b1;
    end

    // Receive path
    if (hs) begin
      if (we_fall && !oe_l) begin
        next_st.rdy_low = 1'b1;
      end
      if (we_rise) begin
        next_st.in_data = st.flt_d[7:0];
        next_st.full = 1'b1;
      end
    end

    // Dual-port modes: a strobe rise starts a busy window
    // Only one channel exists, so priority order never has to arbitrate
    if (st.dual_port_mode_enable && !st.handshake_select_enable
        && (we_rise || oe_rise) && cs_l) begin
      next_st.busy = 4'(BUSY_CYC);
    end else if (st.busy != 4'h0) begin
      next_st.busy = st.busy - 4'h1;
    end
  end

  always_comb begin
    if (hs) begin
      req_low = (st.tx == HPP_TX_WAIT)
                || (st.tx == HPP_TX_DRIVE
                    && st.cnt < 4'(REQ_PULSE_CYC));
    end else if (st.dual_port_mode_enable) begin
      req_low = cs_l && (!st.usable[rs_v] || st.busy != 4'h0);
    end else begin
      req_low = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.s1 <= 14'h3FFF;
      st.s2 <= 14'h3FFF;
      st.s3 <= 14'h3FFF;
      st.flt <= 14'h3FFF;
      st.flt_d <= 14'h3FFF;
      st.dual_port_mode_enable <= CTRL_RESET[CTRL_DUAL_PORT];
      st.handshake_select_enable <= CTRL_RESET[CTRL_HANDSHAKE];
      st.wait_request_output_enable <= CTRL_RESET[CTRL_REQ_OUT_EN];
      st.usable <= CTRL_RESET[CTRL_USE_LSB +: 8];
      st.empty <= 1'b1;
      st.tx <= HPP_TX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave: the access phase always completes at once
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.err & access;

  // Data lines float unless a byte is being presented
  assign port.dev_data_o = st.out_data;
  assign port.dev_data_oe = (st.tx == HPP_TX_DRIVE);
  // Request pin not driven when its enable bit is clear
  assign port.wait_request_o = ~req_low;
  assign port.wait_request_oe = st.wait_request_output_enable;
  assign port.ready_n = ~st.rdy_low;

endmodule

// [hw/hpp_host.sv]
// Purpose: Peer master end: sends bytes by strobe, takes bytes on request.
// Assumes: Device pins asynchronous to pclk; APB master on pclk.
// Notes: Chip and register select come from the control word.
`timescale 1ns/1ps
module hpp_host
  import hpp_pkg::*;
#(
  parameter int unsigned WE_LOW = WE_LOW_CYC,
  parameter int unsigned GAP = GAP_CYC
) (
  input wire logic pclk,           // System clock
  input wire logic presetn,        // Async reset, active low
  input wire logic psel,           // APB select
  input wire logic penable,        // APB access phase
  input wire logic pwrite,         // APB direction
  input wire logic [7:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,      // APB read data
  output logic pready,             // APB ready
  output logic pslverr,            // APB error, unmapped address
  hpp_if.host port                 // Pins to the device
);

  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] flt;
    logic [8:0] flt_d;
    logic rx_en;
    logic cs_en;
    logic [2:0] rs;
    hpp_host_st_t tx;
    logic [7:0] cnt;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic rx_full;
    logic we_n;
    logic oe_n;
    logic [31:0] rdata;
    logic err;
  } hpp_host_state_t;

  hpp_host_state_t st;
  hpp_host_state_t next_st;
  logic setup;
  logic access;
  logic req_rise;
  logic req_idle;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign req_rise = st.flt[HSYN_REQ] & ~st.flt_d[HSYN_REQ];
  assign req_idle = st.flt[HSYN_REQ] & st.flt_d[HSYN_REQ];

  always_comb begin
    next_st = st;
    next_st.s1 = {port.wait_request_out, port.data};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.flt = (st.s3 & ~(st.s2 ^ st.s3)) | (st.flt & (st.s2 ^ st.s3));
    next_st.flt_d = st.flt;
    if (setup) begin
      next_st.err = 1'b0;
      if (paddr == REG_CTRL) begin
        next_st.rdata = {27'h000_0000, st.rs, st.cs_en, st.rx_en};
      end else if (paddr == REG_STAT) begin
        next_st.rdata = {30'h0000_0000, st.rx_full, st.tx != HPP_H_IDLE};
      end else if (paddr == REG_TX) begin
        next_st.rdata = {24'h00_0000, st.tx_data};
      end else if (paddr == REG_RX) begin
        next_st.rdata = {24'h00_0000, st.rx_data};
      end else begin
        next_st.rdata = 32'h0000_0000;
        next_st.err = 1'b1;
      end
    end
    if (access && !pwrite && paddr == REG_RX) begin
      next_st.rx_full = 1'b0;
    end
    if (access && pwrite && paddr == REG_CTRL) begin
      next_st.rx_en = pwdata[HCTRL_RX_EN];
      next_st.cs_en = pwdata[HCTRL_CS_EN];
      next_st.rs = pwdata[HCTRL_RS_LSB +: 3];
    end
    // Send only while the device is not requesting, so turns alternate
    if (access && pwrite && paddr == REG_TX && st.tx == HPP_H_IDLE
        && req_idle) begin
      next_st.tx_data = pwdata[7:0];
      next_st.tx = HPP_H_STROBE;
      next_st.cnt = 8'h00;
    end
    case (st.tx)
      HPP_H_STROBE: begin
        next_st.we_n = 1'b0;
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == 8'(WE_LOW - 1)) begin
          next_st.tx = HPP_H_HOLD;
          next_st.we_n = 1'b1;
        end
      end
      HPP_H_HOLD: begin
        next_st.tx = HPP_H_GAP;
        next_st.cnt = 8'h00;
      end
      HPP_H_GAP: begin
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == 8'(GAP - 1)) begin
          next_st.tx = HPP_H_IDLE;
        end
      end
      default: begin
        next_st.we_n = 1'b1;
      end
    endcase
    if (req_rise && !st.oe_n) begin
      next_st.rx_data = st.flt_d[7:0];
      next_st.rx_full = 1'b1;
    end
    // Enable stays high while sending, full, or receive is off
    next_st.oe_n = ~(next_st.rx_en & ~next_st.rx_full
                     & (next_st.tx == HPP_H_IDLE));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.s1 <= 9'h1FF;
      st.s2 <= 9'h1FF;
      st.s3 <= 9'h1FF;
      st.flt <= 9'h1FF;
      st.flt_d <= 9'h1FF;
      st.we_n <= 1'b1;
      st.oe_n <= 1'b1;
      st.tx <= HPP_H_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.err & access;
  assign port.oe_n = st.oe_n;
  assign port.we_n = st.we_n;
  assign port.cs_n = ~st.cs_en;
  assign port.rs = st.rs;
  assign port.host_data_o = st.tx_data;
  assign port.host_data_oe = (st.tx == HPP_H_STROBE) | (st.tx == HPP_H_HOLD);

endmodule

// [testbench/hpp_chk.sv]
// Purpose: Pin-level checks on the link joining both port ends.
// Assumes: Handshake mode whenever the write strobe moves; pin filter lag 3..4.
// Notes: Dual-port wait requests are judged by the bench, not here.
`timescale 1ns/1ps
module hpp_chk (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic oe_n, // Output enable pin
  input wire logic we_n, // Write strobe pin
  input wire logic [7:0] data, // Resolved data bus
  input wire logic dev_data_oe, // Device drives data
  input wire logic host_data_oe, // Master drives data
  input wire logic wait_request_o, // Device request, active low
  input wire logic ready_n // Device ready, active low
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_latch_pulse;
    (!wait_request_o)[*8] ##1 wait_request_o;
  endsequence
  property p_latch_pulse;
    $rose(dev_data_oe) |-> s_latch_pulse;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse)
    else $error("latch pulse length wrong");
  property p_drive_cause;
    $rose(dev_data_oe) |-> !oe_n && $past(oe_n, 3) == 1'h0;
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("data driven without output enable");
  property p_release;
    $rose(oe_n) |-> ##[1:6] !dev_data_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("data lines not released");
  property p_drop_cause;
    $fell(dev_data_oe) |-> oe_n && $past(oe_n, 2);
  endproperty
  a_drop_cause: assert property (p_drop_cause)
    else $error("drive dropped while enable low");
  property p_ready_low;
    $fell(we_n) && oe_n |-> ##[3:6] !ready_n;
  endproperty
  a_ready_low: assert property (p_ready_low)
    else $error("ready not lowered by strobe");
  property p_request_first;
    $fell(wait_request_o) |-> !dev_data_oe;
  endproperty
  a_request_first: assert property (p_request_first)
    else $error("request raised while driving");
  property p_data_hold;
    dev_data_oe && $past(dev_data_oe) |-> $stable(data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("driven byte changed");
  property p_no_clash;
    dev_data_oe |-> !host_data_oe;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive data");
endmodule

// [testbench/hpp_tb_top.sv]
// Purpose: Self-checking bench joining device and master ends.
// Assumes: APB slaves answer with zero wait states.
// Notes: Mode scans run last; stray outbound bytes may stay behind.
`timescale 1ns/1ps
module hpp_tb_top;
  import hpp_pkg::*;
  logic pclk, presetn, d_psel, h_psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, d_prdata, h_prdata;
  logic d_pready, h_pready, d_pslverr, h_pslverr;
  int n_mismatch, compares, cyc;
  logic [31:0] rd;
  logic er;
  hpp_if link();
  hpp_dev hpp_dev_inst(.pclk, .presetn, .psel(d_psel), .penable, .pwrite,
    .paddr, .pwdata, .prdata(d_prdata), .pready(d_pready),
    .pslverr(d_pslverr), .port(link));
  hpp_host hpp_host_inst(.pclk, .presetn, .psel(h_psel), .penable,
    .pwrite, .paddr, .pwdata, .prdata(h_prdata), .pready(h_pready),
    .pslverr(h_pslverr), .port(link));
  hpp_chk hpp_chk_inst(.pclk, .presetn, .oe_n(link.oe_n),
    .we_n(link.we_n), .data(link.data), .dev_data_oe(link.dev_data_oe),
    .host_data_oe(link.host_data_oe),
    .wait_request_o(link.wait_request_o),
    .ready_n(link.ready_n));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Generous ceiling; the whole sequence needs a few hundred cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input bit h, input bit w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    d_psel <= !h;
    h_psel <= h;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while ((h ? h_pready : d_pready) !== 1'h1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      n_mismatch++;
    end
    q = h ? h_prdata : d_prdata;
    e = h ? h_pslverr : d_pslverr;
    d_psel <= 1'h0;
    h_psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge so a following call never reassigns in this step
    @(posedge pclk);
  endtask
  task automatic wr(input bit h, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(h, 1'h1, a, d, q, e);
  endtask
  task automatic wait_bit(input bit h, input int b, input logic v);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    apb(h, 1'h0, REG_STAT, 32'h0, q, e);
    while (q[b] !== v && n < 100) begin
      n++;
      apb(h, 1'h0, REG_STAT, 32'h0, q, e);
    end
    cmp_pin(q[b], v);
  endtask
  task automatic s_reset_and_map();
    apb(1'h0, 1'h0, REG_CTRL, 32'h0, rd, er);
    cmp_reg(rd, CTRL_RESET);
    apb(1'h0, 1'h0, REG_STAT, 32'h0, rd, er);
    cmp_reg(rd, 32'h0000_0001);
    cmp_pin(link.ready_n, 1'h1);
    apb(1'h0, 1'h0, 8'h10, 32'h0, rd, er);
    cmp_pin(er, 1'h1);
    cmp_reg(rd, 32'h0);
  endtask
  task automatic s_transmit();
    logic [7:0] b[3] = '{8'hA5, 8'h00, 8'hFF};
    wr(1'h1, REG_CTRL, 32'h0000_0001);
    wr(1'h0, REG_CTRL, 32'h0000_FF07);
    foreach (b[i]) begin
      wr(1'h0, REG_TX, {24'h0, b[i]});
      cmp_pin(link.wait_request_out, 1'h0);
      apb(1'h0, 1'h0, REG_STAT, 32'h0, rd, er);
      cmp_pin(rd[ST_EMPTY], 1'h0);
      // A second byte while not empty must be dropped
      if (i == 0) begin
        wr(1'h0, REG_TX, 32'h0000_003C);
      end
      wait_bit(1'h1, HST_RX_FULL, 1'h1);
      apb(1'h1, 1'h0, REG_RX, 32'h0, rd, er);
      cmp_reg(rd, {24'h0, b[i]});
      wait_bit(1'h0, ST_EMPTY, 1'h1);
      repeat (40) @(posedge pclk);
      apb(1'h1, 1'h0, REG_STAT, 32'h0, rd, er);
      cmp_pin(rd[HST_RX_FULL], 1'h0);
    end
  endtask
  task automatic s_receive();
    logic [7:0] b[3] = '{8'h96, 8'h00, 8'hFF};
    wr(1'h0, REG_CTRL, 32'h0000_FF03);
    foreach (b[i]) begin
      wait_bit(1'h1, HST_TX_BUSY, 1'h0);
      wr(1'h1, REG_TX, {24'h0, b[i]});
      wait_bit(1'h0, ST_FULL, 1'h1);
      cmp_pin(link.ready_n, 1'h0);
      cmp_pin(link.wait_request_oe, 1'h0);
      apb(1'h0, 1'h0, REG_RX, 32'h0, rd, er);
      cmp_reg(rd, {24'h0, b[i]});
      cmp_pin(link.ready_n, 1'h1);
      apb(1'h0, 1'h0, REG_STAT, 32'h0, rd, er);
      cmp_pin(rd[ST_FULL], 1'h0);
    end
  endtask
  task automatic s_modes_off();
    logic [1:0] m[3] = '{2'h0, 2'h1, 2'h2};
    foreach (m[i]) begin
      wr(1'h0, REG_CTRL, {30'h0000_3FC1, m[i]});
      wr(1'h0, REG_TX, 32'h0000_005A);
      repeat (16) @(posedge pclk);
      cmp_pin(link.wait_request_out, 1'h1);
      cmp_pin(link.dev_data_oe, 1'h0);
    end
  endtask
  task automatic s_dual_port();
    // Chip select low, register 0, enable high; settle before mode change
    wr(1'h1, REG_CTRL, 32'h0000_0002);
    repeat (8) @(posedge pclk);
    // Dual-port mode with only register 0 usable
    wr(1'h0, REG_CTRL, 32'h0000_0105);
    repeat (8) @(posedge pclk);
    cmp_pin(link.wait_request_out, 1'h1);
    wr(1'h1, REG_CTRL, 32'h0000_0006);
    repeat (8) @(posedge pclk);
    cmp_pin(link.wait_request_out, 1'h0);
    wr(1'h1, REG_CTRL, 32'h0000_0002);
    repeat (8) @(posedge pclk);
    cmp_pin(link.wait_request_out, 1'h1);
    // Lower the enable, then raise it: the rise starts a transfer
    wr(1'h1, REG_CTRL, 32'h0000_0003);
    repeat (8) @(posedge pclk);
    wr(1'h1, REG_CTRL, 32'h0000_0002);
    repeat (6) @(posedge pclk);
    cmp_pin(link.wait_request_out, 1'h0);
    repeat (14) @(posedge pclk);
    cmp_pin(link.wait_request_out, 1'h1);
  endtask
  initial begin
    presetn = 1'h0;
    d_psel = 1'h0;
    h_psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    s_reset_and_map();
    s_transmit();
    s_receive();
    s_modes_off();
    s_dual_port();
    end_of_test();
  end
endmodule
